// File: hw/host_port_pkg.sv
// Constants and types shared by the host register access port.
package host_port_pkg;

  // ==========================================================================
  // Data and register number widths.
  localparam int DATA_W = 8;
  localparam int REG_NUM_W = 8;
  localparam int REG_COUNT = 256;
  localparam int GROUP_W = 4;

  // ==========================================================================
  // Status byte field positions and reset value.
  localparam int STAT_MEM_BUSY_BIT = 7;
  localparam int STAT_BTE_BUSY_BIT = 6;
  localparam int STAT_TOUCH_BIT = 5;
  localparam int STAT_SLEEP_BIT = 4;
  localparam int STAT_FLASH_BUSY_BIT = 0;
  localparam logic [DATA_W-1:0] HOST_STATUS_RESET = 8'h00;

  // ==========================================================================
  // Reset values of the stored registers and of the latched number.
  localparam logic [DATA_W-1:0] INSTR_REG_RESET = 8'h00;
  localparam logic [REG_NUM_W-1:0] REG_NUM_RESET = 8'h00;

  // ==========================================================================
  // The memory data port register is not stored; it streams to memory.
  localparam logic [REG_NUM_W-1:0] MEM_DATA_REG = 8'h02;

  // ==========================================================================
  // Group boundaries of the instruction register number space.
  localparam logic [REG_NUM_W-1:0] SYS_REG_A = 8'h01;
  localparam logic [REG_NUM_W-1:0] SYS_REG_C = 8'h04;
  localparam logic [REG_NUM_W-1:0] SYS_LO = 8'h10;
  localparam logic [REG_NUM_W-1:0] SYS_HI = 8'h1F;
  localparam logic [REG_NUM_W-1:0] LCD_LO = 8'h20;
  localparam logic [REG_NUM_W-1:0] LCD_HI = 8'h29;
  localparam logic [REG_NUM_W-1:0] AWIN_LO = 8'h30;
  localparam logic [REG_NUM_W-1:0] AWIN_HI = 8'h3F;
  localparam logic [REG_NUM_W-1:0] CUR_LO = 8'h40;
  localparam logic [REG_NUM_W-1:0] CUR_HI = 8'h4E;
  localparam logic [REG_NUM_W-1:0] BTE_LO = 8'h50;
  localparam logic [REG_NUM_W-1:0] BTE_HI = 8'h67;
  localparam logic [REG_NUM_W-1:0] TP_LO = 8'h70;
  localparam logic [REG_NUM_W-1:0] TP_HI = 8'h74;
  localparam logic [REG_NUM_W-1:0] GCUR_LO = 8'h80;
  localparam logic [REG_NUM_W-1:0] GCUR_HI = 8'h85;
  localparam logic [REG_NUM_W-1:0] PLL_LO = 8'h88;
  localparam logic [REG_NUM_W-1:0] PLL_HI = 8'h89;
  localparam logic [REG_NUM_W-1:0] PWM_LO = 8'h8A;
  localparam logic [REG_NUM_W-1:0] PWM_HI = 8'h8E;
  localparam logic [REG_NUM_W-1:0] DRAW_LO = 8'h90;
  localparam logic [REG_NUM_W-1:0] DRAW_HI = 8'hAC;
  localparam logic [REG_NUM_W-1:0] DMA_LO = 8'hB0;
  localparam logic [REG_NUM_W-1:0] DMA_HI = 8'hBF;
  localparam logic [REG_NUM_W-1:0] KEY_LO = 8'hC0;
  localparam logic [REG_NUM_W-1:0] KEY_HI = 8'hC7;
  localparam logic [REG_NUM_W-1:0] FWIN_LO = 8'hD0;
  localparam logic [REG_NUM_W-1:0] FWIN_HI = 8'hDB;
  localparam logic [REG_NUM_W-1:0] SFL_LO = 8'hE0;
  localparam logic [REG_NUM_W-1:0] SFL_HI = 8'hE2;
  localparam logic [REG_NUM_W-1:0] INT_LO = 8'hF0;
  localparam logic [REG_NUM_W-1:0] INT_HI = 8'hF1;

  // ==========================================================================
  // Functional groups; NONE marks an unassigned register number.
  typedef enum logic [GROUP_W-1:0] {
    GRP_NONE, GRP_SYS, GRP_LCD, GRP_AWIN, GRP_CURSOR, GRP_BTE, GRP_TOUCH,
    GRP_GCURSOR, GRP_PLL, GRP_PWM, GRP_DRAW, GRP_DMA, GRP_KEYIO, GRP_FWIN,
    GRP_SFLASH, GRP_INT
  } reg_group_t;

  // ==========================================================================
  // The four host cycle kinds, coded as {register_select, read_not_write}.
  typedef enum logic [1:0] {
    CYC_DATA_WRITE, CYC_DATA_READ, CYC_NUM_WRITE, CYC_STATUS_READ
  } cycle_kind_t;

endpackage : host_port_pkg

// File: hw/regfile_if.sv
// Interface between the host port control and the register storage.
`timescale 1ns/10ps
interface regfile_if;
  import host_port_pkg::*;

  // ==========================================================================
  // Write strobe, shared number, write data and read data.
  logic wr_en;
  logic [REG_NUM_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;

  // The port control drives requests; the storage returns data.
  modport ctrl (output wr_en, output addr, output wdata, input rdata);
  modport store (input wr_en, input addr, input wdata, output rdata);
endinterface : regfile_if

// File: hw/instr_reg_store.sv
// Byte-wide storage for the instruction registers.
`timescale 1ns/10ps
module instr_reg_store
  import host_port_pkg::*;
#(
  parameter int DEPTH = REG_COUNT
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Access from the port control.
  regfile_if.store rf
);

  // ==========================================================================
  // Storage array; every entry holds one byte at most.
  logic [DATA_W-1:0] mem_q [DEPTH];

  // Each entry is written only when its number is addressed; all clear
  // on reset so that every register starts at a known value.
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          mem_q[i] <= INSTR_REG_RESET;
        end else if (rf.wr_en && (rf.addr == REG_NUM_W'(i))) begin
          mem_q[i] <= rf.wdata;
        end
      end
    end
  endgenerate

  // Read data follows the addressed entry without delay.
  assign rf.rdata = mem_q[rf.addr];

endmodule : instr_reg_store

// File: hw/host_register_access_port.sv
// Host register access port: cycle decode, number latch, status byte.
`timescale 1ns/10ps
module host_register_access_port
  import host_port_pkg::*;
#(
  parameter int DEPTH = REG_COUNT
) (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // Host bus cycle.
  input wire logic HOST_STB,
  input wire logic REGISTER_SELECT,
  input wire logic READ_NOT_WRITE,
  input wire logic [DATA_W-1:0] HOST_DATA_IN,
  // Host read answer.
  output logic [DATA_W-1:0] HOST_DATA_OUT,
  output logic HOST_DATA_OE,
  // Status sources inside the device.
  input wire logic MEM_BUSY,
  input wire logic BLOCK_TRANSFER_ENGINE_BUSY,
  input wire logic TOUCH_DETECT_RAW,
  input wire logic SLEEP_MODE,
  input wire logic FLASH_BUSY,
  // Register write notice to the device functions.
  output logic [REG_NUM_W-1:0] REG_NUM,
  output logic [GROUP_W-1:0] REG_GROUP,
  output logic REG_WR_STB,
  output logic [DATA_W-1:0] REG_WR_DATA,
  // Display memory data port.
  output logic MEM_WR_STB,
  output logic MEM_RD_STB,
  output logic [DATA_W-1:0] MEM_WR_DATA,
  input wire logic [DATA_W-1:0] MEM_RD_DATA
);

  // ==========================================================================
  // Cycle timing, as seen from the host side of this port.
  //
  // A host cycle is one clock with HOST_STB high. The two select lines
  // name its kind at that same edge, and HOST_DATA_IN carries the byte
  // for writes. Every answer comes exactly one clock after the take:
  //   number write  REG_NUM and REG_GROUP change one clock later;
  //   data write    REG_WR_STB or MEM_WR_STB pulses one clock later;
  //   any read      HOST_DATA_OE pulses and HOST_DATA_OUT is valid.
  // Cycles may follow each other on every clock, in any order. The
  // latched number survives any count of status or data cycles, so a
  // host may poll the status byte between the number and the data.
  //
  // Limitations a user of this port must know:
  //   the status byte lags its sources by one clock, because it is
  //   sampled into a flop so that the read answer never glitches;
  //   the touch bit is passed raw, without any debouncing;
  //   data writes to unassigned numbers are dropped without notice;
  //   reads of unassigned numbers answer zero rather than old data.
  //
  // The trade made here is one clock of latency on every answer in
  // exchange for outputs that all come straight from flops, which keeps
  // the far side free of decode hazards.

  // ==========================================================================
  // Group decode of a register number.
  //
  // The register number space holds fifteen functional groups. Most are
  // a contiguous range; the system group adds three single numbers below
  // its range, among them the memory data port. Every number that falls
  // in no group decodes as GRP_NONE, which the write and read paths use
  // to refuse the access. The decode is a priority chain only for the
  // reader's sake: the ranges do not overlap, so the order carries no
  // meaning and any one number matches at most one branch.
  function automatic reg_group_t group_of(input logic [REG_NUM_W-1:0] n);
    reg_group_t g;
    g = GRP_NONE;
    if (n == SYS_REG_A || n == MEM_DATA_REG || n == SYS_REG_C ||
        (n >= SYS_LO && n <= SYS_HI)) begin
      g = GRP_SYS;
    end else if (n >= LCD_LO && n <= LCD_HI) begin
      g = GRP_LCD;
    end else if (n >= AWIN_LO && n <= AWIN_HI) begin
      g = GRP_AWIN;
    end else if (n >= CUR_LO && n <= CUR_HI) begin
      g = GRP_CURSOR;
    end else if (n >= BTE_LO && n <= BTE_HI) begin
      g = GRP_BTE;
    end else if (n >= TP_LO && n <= TP_HI) begin
      g = GRP_TOUCH;
    end else if (n >= GCUR_LO && n <= GCUR_HI) begin
      g = GRP_GCURSOR;
    end else if (n >= PLL_LO && n <= PLL_HI) begin
      g = GRP_PLL;
    end else if (n >= PWM_LO && n <= PWM_HI) begin
      g = GRP_PWM;
    end else if (n >= DRAW_LO && n <= DRAW_HI) begin
      g = GRP_DRAW;
    end else if (n >= DMA_LO && n <= DMA_HI) begin
      g = GRP_DMA;
    end else if (n >= KEY_LO && n <= KEY_HI) begin
      g = GRP_KEYIO;
    end else if (n >= FWIN_LO && n <= FWIN_HI) begin
      g = GRP_FWIN;
    end else if (n >= SFL_LO && n <= SFL_HI) begin
      g = GRP_SFLASH;
    end else if (n >= INT_LO && n <= INT_HI) begin
      g = GRP_INT;
    end
    return g;
  endfunction : group_of

  // ==========================================================================
  // Internal signals.
  regfile_if rf ();
  cycle_kind_t kind;
  reg_group_t group;
  reg_group_t group_q;
  logic [REG_NUM_W-1:0] reg_num_q;
  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] status_d;
  logic [DATA_W-1:0] data_out_q;
  logic [DATA_W-1:0] data_out_d;
  logic data_oe_q;
  logic reg_wr_q;
  logic [DATA_W-1:0] reg_wr_data_q;
  logic mem_wr_q;
  logic [DATA_W-1:0] mem_wr_data_q;
  logic mem_rd_q;
  logic is_mem_port;
  logic is_mapped;

  // ==========================================================================
  // Cycle decode; the two select lines fully name the cycle kind.
  assign kind = cycle_kind_t'({REGISTER_SELECT, READ_NOT_WRITE});
  assign group = group_of(HOST_DATA_IN);
  assign is_mem_port = (reg_num_q == MEM_DATA_REG);
  assign is_mapped = (group_q != GRP_NONE);

  // Register number latch; only a number write changes it, so a status
  // read between number and data cycles does not disturb the target.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      reg_num_q <= REG_NUM_RESET;
    end else if (HOST_STB && kind == CYC_NUM_WRITE) begin
      reg_num_q <= HOST_DATA_IN;
    end
  end

  // Group of the latched number, decoded as the number is taken, so the
  // group output and the write filter come straight from a flop. It is
  // loaded on the same edge as the number, so the two always agree.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      group_q <= GRP_NONE;
    end else if (HOST_STB && kind == CYC_NUM_WRITE) begin
      group_q <= group;
    end
  end

  // ==========================================================================
  // Status byte is sampled each cycle so the read answer is a flop output;
  // the touch bit is passed raw, so the host must filter bounce itself.
  always_comb begin
    status_d = HOST_STATUS_RESET;
    status_d[STAT_MEM_BUSY_BIT] = MEM_BUSY;
    status_d[STAT_BTE_BUSY_BIT] = BLOCK_TRANSFER_ENGINE_BUSY;
    status_d[STAT_TOUCH_BIT] = TOUCH_DETECT_RAW;
    status_d[STAT_SLEEP_BIT] = SLEEP_MODE;
    status_d[STAT_FLASH_BUSY_BIT] = FLASH_BUSY;
  end

  // Status holding flop; it has no write path at all.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status_q <= HOST_STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // ==========================================================================
  // Data writes go either to the memory port or to register storage.
  // Unassigned numbers are dropped so the storage stays clean.
  assign rf.addr = reg_num_q;
  assign rf.wdata = HOST_DATA_IN;
  assign rf.wr_en = HOST_STB && kind == CYC_DATA_WRITE &&
                    is_mapped && !is_mem_port;

  // Register write notice, one cycle after the data write is taken.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      reg_wr_q <= 1'b0;
      reg_wr_data_q <= INSTR_REG_RESET;
    end else begin
      reg_wr_q <= rf.wr_en;
      if (rf.wr_en) begin
        reg_wr_data_q <= HOST_DATA_IN;
      end
    end
  end

  // Memory port strobes; reads and writes of memory stream through here.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mem_wr_q <= 1'b0;
      mem_wr_data_q <= INSTR_REG_RESET;
      mem_rd_q <= 1'b0;
    end else begin
      mem_wr_q <= HOST_STB && kind == CYC_DATA_WRITE && is_mem_port;
      mem_rd_q <= HOST_STB && kind == CYC_DATA_READ && is_mem_port;
      if (HOST_STB && kind == CYC_DATA_WRITE && is_mem_port) begin
        mem_wr_data_q <= HOST_DATA_IN;
      end
    end
  end

  // ==========================================================================
  // Read answer select; unassigned numbers read as zero.
  always_comb begin
    data_out_d = data_out_q;
    case (kind)
      CYC_STATUS_READ: begin
        data_out_d = status_q;
      end
      CYC_DATA_READ: begin
        if (is_mem_port) begin
          data_out_d = MEM_RD_DATA;
        end else if (is_mapped) begin
          data_out_d = rf.rdata;
        end else begin
          data_out_d = INSTR_REG_RESET;
        end
      end
      default: begin
        data_out_d = data_out_q;
      end
    endcase
  end

  // Read data and its enable; data holds until the next read cycle.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      data_out_q <= INSTR_REG_RESET;
      data_oe_q <= 1'b0;
    end else begin
      data_oe_q <= HOST_STB && READ_NOT_WRITE;
      if (HOST_STB && READ_NOT_WRITE) begin
        data_out_q <= data_out_d;
      end
    end
  end

  // ==========================================================================
  // Register storage.
  instr_reg_store #(
    .DEPTH(DEPTH)
  ) u_store (
    .clk(CORE_CLK),
    .reset_n(RESET_N),
    .rf(rf.store)
  );

  // ==========================================================================
  // Outputs.
  //
  // Every output below is a plain copy of a flop. The strobes are single
  // clock pulses; the data and number outputs hold until replaced, so a
  // slow consumer may pick them up at any later clock.
  assign HOST_DATA_OUT = data_out_q;
  assign HOST_DATA_OE = data_oe_q;
  assign REG_NUM = reg_num_q;
  assign REG_GROUP = group_q;
  assign REG_WR_STB = reg_wr_q;
  assign REG_WR_DATA = reg_wr_data_q;
  assign MEM_WR_STB = mem_wr_q;
  assign MEM_RD_STB = mem_rd_q;
  assign MEM_WR_DATA = mem_wr_data_q;

endmodule : host_register_access_port

// File: testbench/host_port_chk.sv
// Checker of the host register access port cycle rules.
`timescale 1ns/10ps
// ==========================================================
module host_port_chk
  import host_port_pkg::*;
(
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // Host cycle and answer.
  input wire logic HOST_STB,
  input wire logic REGISTER_SELECT,
  input wire logic READ_NOT_WRITE,
  input wire logic [DATA_W-1:0] HOST_DATA_IN,
  input wire logic [DATA_W-1:0] HOST_DATA_OUT,
  input wire logic HOST_DATA_OE,
  // Register and memory notices.
  input wire logic [REG_NUM_W-1:0] REG_NUM,
  input wire logic [GROUP_W-1:0] REG_GROUP,
  input wire logic REG_WR_STB,
  input wire logic [DATA_W-1:0] REG_WR_DATA,
  input wire logic MEM_WR_STB,
  input wire logic MEM_RD_STB,
  input wire logic [DATA_W-1:0] MEM_WR_DATA,
  input wire logic [DATA_W-1:0] MEM_RD_DATA
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // Cycle kinds; the memory port number bypasses the storage.
  wire nw = HOST_STB && REGISTER_SELECT && !READ_NOT_WRITE;
  wire rd = HOST_STB && READ_NOT_WRITE;
  wire dw = HOST_STB && !REGISTER_SELECT && !READ_NOT_WRITE;
  wire mp = REG_NUM == MEM_DATA_REG;
  a_num_latch: assert property (nw |=> REG_NUM == $past(HOST_DATA_IN))
    else $error("number write not latched");
  a_num_hold: assert property (!nw |=> $stable(REG_NUM))
    else $error("register number changed without number write");
  a_read_answer: assert property (rd |=> HOST_DATA_OE)
    else $error("read cycle without answer");
  a_oe_cause: assert property (HOST_DATA_OE |-> $past(rd))
    else $error("data bus driven without read cycle");
  a_reg_write: assert property (dw && !mp && REG_GROUP != GRP_NONE |=>
    REG_WR_STB && REG_WR_DATA == $past(HOST_DATA_IN))
    else $error("data write not stored");
  a_mem_write: assert property (dw && mp |=> MEM_WR_STB && !REG_WR_STB &&
    MEM_WR_DATA == $past(HOST_DATA_IN))
    else $error("memory write not passed on");
  a_mem_read: assert property (rd && !REGISTER_SELECT && mp |=>
    MEM_RD_STB && HOST_DATA_OUT == $past(MEM_RD_DATA))
    else $error("memory read not returned");
  a_no_write: assert property (!dw |=> !REG_WR_STB && !MEM_WR_STB)
    else $error("write strobe without data write");
  a_unassigned: assert property (dw && REG_GROUP == GRP_NONE |=>
    !REG_WR_STB && !MEM_WR_STB)
    else $error("write to unassigned number accepted");
  a_group_lcd: assert property (REG_NUM inside {[LCD_LO:LCD_HI]} |->
    REG_GROUP == GRP_LCD)
    else $error("display control group misdecoded");
  a_reset_clear: assert property (disable iff (1'b0) !RESET_N |->
    REG_NUM == 8'h00 && !HOST_DATA_OE && !REG_WR_STB)
    else $error("outputs not cleared in reset");
  c_num: cover property (nw);
  c_mem: cover property (dw && mp);
  c_stat: cover property (rd && REGISTER_SELECT);
endmodule : host_port_chk

bind host_register_access_port host_port_chk u_chk (.CORE_CLK(CORE_CLK),
  .RESET_N(RESET_N), .HOST_STB(HOST_STB), .REGISTER_SELECT(REGISTER_SELECT),
  .READ_NOT_WRITE(READ_NOT_WRITE), .HOST_DATA_IN(HOST_DATA_IN),
  .HOST_DATA_OUT(HOST_DATA_OUT), .HOST_DATA_OE(HOST_DATA_OE),
  .REG_NUM(REG_NUM), .REG_GROUP(REG_GROUP), .REG_WR_STB(REG_WR_STB),
  .REG_WR_DATA(REG_WR_DATA), .MEM_WR_STB(MEM_WR_STB),
  .MEM_RD_STB(MEM_RD_STB), .MEM_WR_DATA(MEM_WR_DATA),
  .MEM_RD_DATA(MEM_RD_DATA));

// File: testbench/host_mcu_model.sv
// Behavioural host microcontroller on the parallel register bus.
`timescale 1ns/10ps
// ==========================================================
module host_mcu_model
  import host_port_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Bus cycle towards the device.
  output logic stb,
  output logic rs,
  output logic rnw,
  output logic [DATA_W-1:0] din,
  // Read answer.
  input wire logic [DATA_W-1:0] dout,
  input wire logic oe
);
  // Idle bus at time zero.
  initial begin
    stb = 1'b0;
    rs = 1'b0;
    rnw = 1'b0;
    din = 8'h00;
  end
  // One cycle of a kind from {rs, rnw}; released data is inverted so a
  // stale byte can never pass for a fresh one.
  task automatic cyc(input logic s, input logic r, input logic [7:0] d,
    output logic [7:0] q, output logic a);
    @(negedge clk);
    stb = 1'b1;
    rs = s;
    rnw = r;
    din = d;
    @(negedge clk);
    q = dout;
    a = oe;
    stb = 1'b0;
    din = ~d;
  endtask : cyc
  // Program a register: number write, then data write.
  task automatic wr_reg(input logic [7:0] n, input logic [7:0] d);
    logic [7:0] q;
    logic a;
    cyc(1'b1, 1'b0, n, q, a);
    cyc(1'b0, 1'b0, d, q, a);
  endtask : wr_reg
  // Read a register: number write, then data read.
  task automatic rd_reg(input logic [7:0] n, output logic [7:0] q);
    logic a;
    cyc(1'b1, 1'b0, n, q, a);
    cyc(1'b0, 1'b1, 8'h00, q, a);
  endtask : rd_reg
  // Touch is trusted only if three polls agree; otherwise 0 is returned.
  task automatic poll(output logic [7:0] q);
    logic [7:0] p;
    logic a;
    cyc(1'b1, 1'b1, 8'h00, q, a);
    repeat (2) begin
      cyc(1'b1, 1'b1, 8'h00, p, a);
      if (p !== q) q = 8'h00;
    end
  endtask : poll
endmodule : host_mcu_model

// File: testbench/host_register_access_port_tb.sv
// Self-checking bench of the host register access port.
`timescale 1ns/10ps
// ==========================================================
module host_register_access_port_tb;
  import host_port_pkg::*;
  logic clk, rst_n, stb, rs, rnw, oe, a, wst, mwst, mrst;
  logic [4:0] src;
  logic [7:0] din, dout, num, wdat, mwdat, mrdat, q, d;
  logic [3:0] grp;
  int num_errors, checked;
  logic [7:0] r_num [17] = '{8'h01, 8'h20, 8'h3F, 8'h4E, 8'h50, 8'h74,
    8'h80, 8'h89, 8'h8A, 8'hAC, 8'hB0, 8'hC7, 8'hDB, 8'hE0, 8'hF1, 8'h03,
    8'h8F};
  reg_group_t r_grp [17] = '{GRP_SYS, GRP_LCD, GRP_AWIN, GRP_CURSOR,
    GRP_BTE, GRP_TOUCH, GRP_GCURSOR, GRP_PLL, GRP_PWM, GRP_DRAW, GRP_DMA,
    GRP_KEYIO, GRP_FWIN, GRP_SFLASH, GRP_INT, GRP_NONE, GRP_NONE};
  host_mcu_model u_host (.clk(clk), .stb(stb), .rs(rs), .rnw(rnw),
    .din(din), .dout(dout), .oe(oe));
  host_register_access_port u_dut (.CORE_CLK(clk), .RESET_N(rst_n),
    .HOST_STB(stb), .REGISTER_SELECT(rs), .READ_NOT_WRITE(rnw),
    .HOST_DATA_IN(din), .HOST_DATA_OUT(dout), .HOST_DATA_OE(oe),
    .MEM_BUSY(src[4]), .BLOCK_TRANSFER_ENGINE_BUSY(src[3]),
    .TOUCH_DETECT_RAW(src[2]), .SLEEP_MODE(src[1]), .FLASH_BUSY(src[0]),
    .REG_NUM(num), .REG_GROUP(grp), .REG_WR_STB(wst), .REG_WR_DATA(wdat),
    .MEM_WR_STB(mwst), .MEM_RD_STB(mrst), .MEM_WR_DATA(mwdat),
    .MEM_RD_DATA(mrdat));
  // Free-running clock at 40 MHz.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Compare one value and count the outcome.
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Expected status byte from the five sources; bits 3 to 1 stay zero.
  function automatic logic [7:0] stat(input logic [4:0] s);
    stat = 8'h00;
    stat[STAT_MEM_BUSY_BIT] = s[4];
    stat[STAT_BTE_BUSY_BIT] = s[3];
    stat[STAT_TOUCH_BIT] = s[2];
    stat[STAT_SLEEP_BIT] = s[1];
    stat[STAT_FLASH_BUSY_BIT] = s[0];
  endfunction : stat
  task automatic final_report;
    $display("errors=%0d checked=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // Watchdog, far beyond the few hundred cycles the tests need.
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
  // Main sequence: reset, table of registers, then hand-written cases.
  initial begin
    num_errors = 0;
    checked = 0;
    rst_n = 1'b0;
    src = 5'h00;
    mrdat = 8'h3C;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    chk(num, REG_NUM_RESET);
    u_host.cyc(1'b1, 1'b1, 8'h00, q, a);
    chk(q, HOST_STATUS_RESET);
    chk(8'(a), 8'h01);
    for (int i = 0; i < 17; i++) begin
      d = r_num[i] ^ 8'hA5;
      u_host.wr_reg(r_num[i], d);
      chk(8'(grp), 8'(r_grp[i]));
      chk(8'(wst), 8'(r_grp[i] != GRP_NONE));
      u_host.rd_reg(r_num[i], q);
      chk(q, (r_grp[i] == GRP_NONE) ? 8'h00 : d);
    end
    for (int b = 0; b < 6; b++) begin
      @(negedge clk);
      src = (b == 5) ? 5'h1F : 5'h01 << b;
      u_host.cyc(1'b1, 1'b1, 8'h00, q, a);
      chk(q, stat(src));
    end
    src = 5'h04;
    u_host.poll(q);
    chk(q, stat(5'h04));
    u_host.wr_reg(MEM_DATA_REG, 8'h5A);
    chk(8'(mwst), 8'h01);
    chk(mwdat, 8'h5A);
    chk(8'(wst), 8'h00);
    u_host.cyc(1'b0, 1'b1, 8'h00, q, a);
    chk(q, 8'h3C);
    chk(8'(mrst), 8'h01);
    u_host.cyc(1'b1, 1'b0, 8'h20, q, a);
    u_host.cyc(1'b1, 1'b1, 8'h00, q, a);
    u_host.cyc(1'b0, 1'b1, 8'h00, q, a);
    chk(q, 8'h20 ^ 8'hA5);
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    chk(num, 8'h00);
    chk(dout, 8'h00);
    rst_n = 1'b1;
    u_host.rd_reg(8'h20, q);
    chk(q, INSTR_REG_RESET);
    final_report();
  end
endmodule : host_register_access_port_tb
